// ### logic/mpt_trip_logic.sv
// motor protection trip and alarm decision logic with register port
// What this block does
// - short circuit armed always, unless level off
// - short circuit level 4 to 12 times
// - instant or delayed trip, delay ignored if off
// - overload alarm immediate above 1.01-1.50 level
// - overload alarm never latches
// - stator max over first configured sensors only
// - per-sensor trip and alarm thresholds
// - open sensors flagged and excluded
// - open sensor alarm unless both thresholds off
// - temperature reset blocked until 4 C below
// - 8 or 10 inputs, last may be ambient
// - overload curve acts above full load only
// - custom flag picks breakpoints, else standard curve
// - standard curves map 1.05-8.00 to seconds
// - 22 custom breakpoints, interpolated where time falls
// - custom curve steps where time rises
// - curve changes wait until motor stops
// - phase reversal trip within 3.5 s of start
`timescale 1ns/1ps
`default_nettype none
module mpt_trip_logic
	import mpt_pkg::*;
#(
	parameter int NSENS      = 10,
	parameter int TICK_COUNT = TICK_CYCLES
)(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [7:0]            addr,
	input  wire logic [31:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic [31:0]                rdata,
	input  wire logic [15:0]           avgCurrent,
	input  wire logic [15:0]           maxCurrent,
	input  wire logic                  motorRunning,
	input  wire logic                  motorStart,
	input  wire logic                  phaseReversed,
	input  wire logic [NSENS-1:0][7:0] temps,
	input  wire logic [NSENS-1:0]      sensorOpen,
	output logic                       tripOut,
	output logic                       alarmOut,
	output logic                       scTripOut,
	output logic                       olTripOut,
	output logic                       ioAlarmOut,
	output logic                       tempTripOut,
	output logic                       tempAlarmOut,
	output logic                       openSensorIndication,
	output logic                       phaseTripOut,
	output logic [7:0]                 statorMaxTemp,
	output logic [7:0]                 ambientTemp,
	output logic                       irq
);
	typedef struct packed {
		logic                       actCustom;
		logic [2:0]                 actSel;
		logic                       pendCustom;
		logic [2:0]                 pendSel;
		logic                       phaseEn;
		logic                       noSensEn;
		logic                       ambEn;
		logic [2:0]                 statorCnt;
		logic [15:0]                scLevel;
		logic [7:0]                 scDelay;
		logic [15:0]                ioLevel;
		logic [NEV-1:0]             irqEn;
		logic [NEV-1:0]             status;
		logic [NEV-1:0]             evPrev;
		logic [NPOINTS-1:0][15:0]   custPend;
		logic [NPOINTS-1:0][15:0]   custAct;
		logic [NSENS-1:0][7:0]      tTripThr;
		logic [NSENS-1:0][7:0]      tAlarmThr;
		logic [NSENS-1:0]           tTripLat;
		logic [NSENS-1:0]           tAlarmLat;
		logic                       tempTrip;
		logic                       tempAlarm;
		logic [31:0]                tickCnt;
		logic [7:0]                 scTimer;
		logic                       scTrip;
		logic [23:0]                olTicks;
		logic                       olTrip;
		logic                       ioAlarm;
		logic [7:0]                 prWin;
		logic                       prTrip;
		logic                       openFlag;
		logic [7:0]                 statorMax;
		logic [7:0]                 ambient;
		logic [15:0]                tripTime;
		logic                       tripOut;
		logic                       alarmOut;
		logic                       irq;
		logic [31:0]                rdata;
	} mpt_state_t;

	mpt_state_t s_q;
	mpt_state_t s_d;

	// trip seconds for a current; flat step where a custom time rises
	function automatic logic [15:0] mpt_curve_time(
		input logic [15:0]                 x,
		input logic [NPOINTS-1:0][15:0]    t
	);
		logic [31:0] drop;
		logic [31:0] span;
		logic [31:0] off;
		logic [15:0] res;
		int          seg;
		seg = -1;
		res = t[0];
		for (int i = 0; i < NPOINTS - 1; i++)
		begin
			if (x >= OL_LEVELS[i] && x < OL_LEVELS[i+1])
				seg = i;
		end
		if (x >= OL_LEVELS[NPOINTS-1])
			res = t[NPOINTS-1];
		if (seg >= 0)
		begin
			if (t[seg+1] > t[seg])
				res = t[seg];
			else
			begin
				drop = 32'(t[seg] - t[seg+1]);
				span = 32'(OL_LEVELS[seg+1] - OL_LEVELS[seg]);
				off  = 32'(x - OL_LEVELS[seg]);
				res  = t[seg] - 16'((drop * off) / span);
			end
		end
		return res;
	endfunction

	function automatic logic [15:0] mpt_clamp(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic [15:0] r;
		r = v;
		if (v == LEVEL_OFF)
			r = LEVEL_OFF;
		else if (v < lo)
			r = lo;
		else if (v > hi)
			r = hi;
		return r;
	endfunction

	logic [NPOINTS-1:0][15:0] stdTimes;
	logic [NPOINTS-1:0][15:0] curTimes;
	always_comb
	begin
		for (int i = 0; i < NPOINTS; i++)
			stdTimes[i] = STD_CURVE[i][s_q.actSel];
		curTimes = s_q.actCustom ? s_q.custAct : stdTimes;
	end

	always_comb
	begin
		logic          tick;
		logic          relayReset;
		logic [NEV-1:0] ev;
		logic [NEV-1:0] evRise;
		logic [8:0]    rd9;
		logic          anyOpen;
		int            idx;
		s_d        = s_q;
		tick       = 1'b0;
		relayReset = wr && addr == A_CTRL && wdata[CTRL_RESET];
		ev         = '0;
		evRise     = '0;
		rd9        = '0;
		anyOpen    = 1'b0;
		idx        = 0;

		// slow time base for delays and overload accumulation
		if (s_q.tickCnt >= 32'(TICK_COUNT - 1))
		begin
			s_d.tickCnt = '0;
			tick        = 1'b1;
		end
		else
			s_d.tickCnt = s_q.tickCnt + 32'h1;

		// register writes
		if (wr)
		begin
			case (addr)
				A_CTRL:
				begin
					s_d.pendCustom = wdata[CTRL_CUSTOM];
					s_d.pendSel    = wdata[CTRL_SEL +: 3];
					s_d.phaseEn    = wdata[CTRL_PHASE];
					s_d.noSensEn   = wdata[CTRL_NOSENS];
					s_d.ambEn      = wdata[CTRL_AMB];
					s_d.statorCnt  = (wdata[CTRL_STATOR +: 3] > 3'(STATOR_MAX)) ?
						3'(STATOR_MAX) : wdata[CTRL_STATOR +: 3];
				end
				A_SC_LEVEL: s_d.scLevel = mpt_clamp(wdata[15:0], SC_LEVEL_LO, SC_LEVEL_HI);
				A_SC_DELAY: s_d.scDelay = (wdata[7:0] > 8'(SC_DELAY_MAX)) ?
					8'(SC_DELAY_MAX) : wdata[7:0];
				A_IO_LEVEL: s_d.ioLevel = mpt_clamp(wdata[15:0], IO_LEVEL_LO, IO_LEVEL_HI);
				A_IRQ_EN:   s_d.irqEn = wdata[NEV-1:0];
				A_CUSTOM:
				begin
					if (wdata[CUST_IDX +: 5] < 5'(NPOINTS))
						s_d.custPend[wdata[CUST_IDX +: 5]] = wdata[15:0];
				end
				default:
				begin
					if (addr >= A_TEMP_TRIP && addr < A_TEMP_TRIP + 8'(4 * NSENS))
						s_d.tTripThr[(addr - A_TEMP_TRIP) >> 2] = wdata[7:0];
					else if (addr >= A_TEMP_ALARM && addr < A_TEMP_ALARM + 8'(4 * NSENS))
						s_d.tAlarmThr[(addr - A_TEMP_ALARM) >> 2] = wdata[7:0];
				end
			endcase
		end

		// curve choice only takes effect with the motor at rest
		if (!motorRunning)
		begin
			s_d.actCustom = s_q.pendCustom;
			s_d.actSel    = s_q.pendSel;
			s_d.custAct   = s_q.custPend;
		end

		// short circuit: no dependence on motor state
		if (s_q.scLevel == LEVEL_OFF)
			s_d.scTimer = '0;
		else if (maxCurrent >= s_q.scLevel)
		begin
			if (s_q.scTimer >= s_q.scDelay)
				s_d.scTrip = 1'b1;
			else if (tick)
				s_d.scTimer = s_q.scTimer + 8'h1;
		end
		else
			s_d.scTimer = '0;

		// immediate overload alarm follows the condition
		s_d.ioAlarm = (s_q.ioLevel != LEVEL_OFF) && (avgCurrent > s_q.ioLevel);

		// overload: time spent above full load against the curve
		s_d.tripTime = mpt_curve_time(avgCurrent, curTimes);
		if (avgCurrent > FULL_LOAD)
		begin
			if (tick && s_q.olTicks != '1)
				s_d.olTicks = s_q.olTicks + 24'h1;
			if (s_q.olTicks >= 24'(s_q.tripTime) * 24'h00000A)
				s_d.olTrip = 1'b1;
		end
		else
			s_d.olTicks = '0;

		// phase sequence check window after each start
		if (motorStart && s_q.phaseEn)
			s_d.prWin = 8'(PR_WIN_TICKS);
		else if (tick && s_q.prWin != 8'h00)
			s_d.prWin = s_q.prWin - 8'h01;
		if (s_q.prWin != 8'h00 && phaseReversed)
			s_d.prTrip = 1'b1;

		// temperature inputs
		s_d.statorMax = '0;
		for (int i = 0; i < NSENS; i++)
		begin
			rd9 = {1'b0, temps[i]};
			if (sensorOpen[i])
			begin
				if (s_q.noSensEn && !(s_q.tTripThr[i] == TEMP_OFF && s_q.tAlarmThr[i] == TEMP_OFF))
					anyOpen = 1'b1;
			end
			else
			begin
				if (s_q.tTripThr[i] != TEMP_OFF && temps[i] > s_q.tTripThr[i])
					s_d.tTripLat[i] = 1'b1;
				else if (relayReset && rd9 + TEMP_HYST <= {1'b0, s_q.tTripThr[i]})
					s_d.tTripLat[i] = 1'b0;
				if (s_q.tAlarmThr[i] != TEMP_OFF && temps[i] > s_q.tAlarmThr[i])
					s_d.tAlarmLat[i] = 1'b1;
				else if (relayReset && rd9 + TEMP_HYST <= {1'b0, s_q.tAlarmThr[i]})
					s_d.tAlarmLat[i] = 1'b0;
				if (i < int'(s_q.statorCnt) && temps[i] > s_d.statorMax)
					s_d.statorMax = temps[i];
			end
		end
		// an open sensor keeps its latch; only the cooled path above, taken when not open, releases it
		s_d.tempTrip  = |s_d.tTripLat;
		s_d.tempAlarm = |s_d.tAlarmLat;
		s_d.openFlag = |sensorOpen;
		s_d.ambient  = (s_q.ambEn && !sensorOpen[NSENS-1]) ? temps[NSENS-1] : 8'h00;

		// software reset of latched trips other than temperature
		if (relayReset)
		begin
			if (maxCurrent < s_q.scLevel || s_q.scLevel == LEVEL_OFF)
				s_d.scTrip = 1'b0;
			if (avgCurrent <= FULL_LOAD)
				s_d.olTrip = 1'b0;
			if (s_q.prWin == 8'h00)
				s_d.prTrip = 1'b0;
		end

		s_d.tripOut  = s_q.scTrip | s_q.olTrip | s_q.prTrip | s_q.tempTrip;
		s_d.alarmOut = s_q.ioAlarm | s_q.tempAlarm | anyOpen;

		// sticky status: a new event outranks a clear in the same cycle
		ev[EV_SC]   = s_q.scTrip;
		ev[EV_OL]   = s_q.olTrip;
		ev[EV_IO]   = s_q.ioAlarm;
		ev[EV_TT]   = s_q.tempTrip;
		ev[EV_TA]   = s_q.tempAlarm;
		ev[EV_OPEN] = anyOpen;
		ev[EV_PR]   = s_q.prTrip;
		evRise      = ev & ~s_q.evPrev;
		s_d.evPrev  = ev;
		if (wr && addr == A_IRQ_CLR)
			s_d.status = s_q.status & ~wdata[NEV-1:0];
		s_d.status = s_d.status | evRise;
		s_d.irq    = |(s_q.status & s_q.irqEn);

		// register reads, data valid the cycle after the strobe
		s_d.rdata = '0;
		if (rd)
		begin
			case (addr)
				A_CTRL:
				begin
					s_d.rdata[CTRL_CUSTOM]       = s_q.pendCustom;
					s_d.rdata[CTRL_SEL +: 3]     = s_q.pendSel;
					s_d.rdata[CTRL_PHASE]        = s_q.phaseEn;
					s_d.rdata[CTRL_NOSENS]       = s_q.noSensEn;
					s_d.rdata[CTRL_AMB]          = s_q.ambEn;
					s_d.rdata[CTRL_STATOR +: 3]  = s_q.statorCnt;
				end
				A_SC_LEVEL:  s_d.rdata[15:0] = s_q.scLevel;
				A_SC_DELAY:  s_d.rdata[7:0]  = s_q.scDelay;
				A_IO_LEVEL:  s_d.rdata[15:0] = s_q.ioLevel;
				A_STATUS:    s_d.rdata[NEV-1:0] = s_q.status;
				A_IRQ_EN:    s_d.rdata[NEV-1:0] = s_q.irqEn;
				A_STATE:
				begin
					s_d.rdata[NEV-1:0] = ev;
					s_d.rdata[8]       = (s_q.pendSel != s_q.actSel) ||
						(s_q.pendCustom != s_q.actCustom) || (s_q.custPend != s_q.custAct);
					s_d.rdata[23:16]   = s_q.statorMax;
				end
				A_TRIP_TIME: s_d.rdata[15:0] = s_q.tripTime;
				default:
				begin
					if (addr >= A_TEMP_TRIP && addr < A_TEMP_TRIP + 8'(4 * NSENS))
					begin
						idx = int'((addr - A_TEMP_TRIP) >> 2);
						s_d.rdata[7:0] = s_q.tTripThr[idx];
					end
					else if (addr >= A_TEMP_ALARM && addr < A_TEMP_ALARM + 8'(4 * NSENS))
					begin
						idx = int'((addr - A_TEMP_ALARM) >> 2);
						s_d.rdata[7:0] = s_q.tAlarmThr[idx];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q            <= '0;
			s_q.actSel     <= SEL_RESET;
			s_q.pendSel    <= SEL_RESET;
			s_q.statorCnt  <= STATOR_RESET;
			s_q.tTripThr   <= {NSENS{TEMP_OFF}};
			s_q.tAlarmThr  <= {NSENS{TEMP_OFF}};
			for (int i = 0; i < NPOINTS; i++)
			begin
				s_q.custPend[i] <= STD_CURVE[i][SEL_RESET];
				s_q.custAct[i]  <= STD_CURVE[i][SEL_RESET];
			end
		end
		else
			s_q <= s_d;
	end

	assign rdata                = s_q.rdata;
	assign tripOut              = s_q.tripOut;
	assign alarmOut             = s_q.alarmOut;
	assign scTripOut            = s_q.scTrip;
	assign olTripOut            = s_q.olTrip;
	assign ioAlarmOut           = s_q.ioAlarm;
	assign tempTripOut          = s_q.tempTrip;
	assign tempAlarmOut         = s_q.tempAlarm;
	assign openSensorIndication = s_q.openFlag;
	assign phaseTripOut         = s_q.prTrip;
	assign statorMaxTemp        = s_q.statorMax;
	assign ambientTemp          = s_q.ambient;
	assign irq                  = s_q.irq;
endmodule // mpt_trip_logic
`default_nettype wire

// ### logic/mpt_pkg.sv
// constants, register map and overload tables for the motor protection trip logic
package mpt_pkg;
	localparam int CLK_HZ       = 50_000_000;
	localparam int TICK_MS      = 100;
	localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
	localparam int PR_WIN_MS    = 3500;
	localparam int PR_WIN_TICKS = PR_WIN_MS / TICK_MS;
	localparam int SC_DELAY_MAX = 205;

	localparam logic [15:0] FULL_LOAD   = 16'h0064;
	localparam logic [15:0] SC_LEVEL_LO = 16'h0190;
	localparam logic [15:0] SC_LEVEL_HI = 16'h04B0;
	localparam logic [15:0] IO_LEVEL_LO = 16'h0065;
	localparam logic [15:0] IO_LEVEL_HI = 16'h0096;
	localparam logic [15:0] LEVEL_OFF   = 16'h0000;
	localparam logic [7:0]  TEMP_OFF    = 8'hFF;
	localparam logic [8:0]  TEMP_HYST   = 9'h004;
	localparam int          STATOR_MAX  = 6;
	localparam int          NPOINTS     = 22;

	localparam logic [7:0] A_CTRL       = 8'h00;
	localparam logic [7:0] A_SC_LEVEL   = 8'h04;
	localparam logic [7:0] A_SC_DELAY   = 8'h08;
	localparam logic [7:0] A_IO_LEVEL   = 8'h0C;
	localparam logic [7:0] A_STATUS     = 8'h10;
	localparam logic [7:0] A_IRQ_EN     = 8'h14;
	localparam logic [7:0] A_IRQ_CLR    = 8'h18;
	localparam logic [7:0] A_STATE      = 8'h1C;
	localparam logic [7:0] A_CUSTOM     = 8'h20;
	localparam logic [7:0] A_TRIP_TIME  = 8'h24;
	localparam logic [7:0] A_TEMP_TRIP  = 8'h40;
	localparam logic [7:0] A_TEMP_ALARM = 8'h80;

	localparam int CTRL_CUSTOM = 0;
	localparam int CTRL_SEL    = 1;
	localparam int CTRL_PHASE  = 4;
	localparam int CTRL_NOSENS = 5;
	localparam int CTRL_AMB    = 6;
	localparam int CTRL_RESET  = 7;
	localparam int CTRL_STATOR = 8;
	localparam int CUST_IDX    = 16;

	localparam logic [2:0] SEL_RESET    = 3'h3;
	localparam logic [2:0] STATOR_RESET = 3'h6;

	localparam int EV_SC = 0;
	localparam int EV_OL = 1;
	localparam int EV_IO = 2;
	localparam int EV_TT = 3;
	localparam int EV_TA = 4;
	localparam int EV_OPEN = 5;
	localparam int EV_PR = 6;
	localparam int NEV = 7;

	// overload level in hundredths of full load
	localparam logic [0:21][15:0] OL_LEVELS = '{105, 110, 120, 130, 140, 150, 175, 200, 225,
		250, 275, 300, 350, 400, 450, 500, 550, 600, 650, 700, 750, 800};
	// trip seconds per level, curves 1..8
	localparam logic [0:21][0:7][15:0] STD_CURVE = '{
		'{853, 1707, 2560, 3414, 5975, 7682, 10243, 12804},
		'{416, 833, 1250, 1666, 2916, 3750, 5000, 6250},
		'{198, 397, 596, 795, 1392, 1789, 2386, 2982},
		'{126, 253, 380, 507, 887, 1141, 1521, 1902},
		'{91, 182, 273, 364, 638, 820, 1093, 1367},
		'{70, 140, 210, 280, 490, 630, 840, 1050},
		'{42, 84, 127, 169, 297, 381, 509, 636},
		'{29, 58, 87, 116, 204, 262, 350, 437},
		'{21, 43, 64, 86, 150, 193, 258, 323},
		'{16, 33, 50, 66, 116, 150, 200, 250},
		'{13, 26, 39, 53, 93, 119, 159, 199},
		'{10, 21, 32, 43, 76, 98, 131, 164},
		'{7, 15, 23, 31, 54, 69, 93, 116},
		'{5, 11, 17, 23, 40, 52, 69, 87},
		'{4, 9, 13, 18, 31, 40, 54, 68},
		'{3, 7, 10, 14, 25, 32, 43, 54},
		'{2, 5, 8, 11, 20, 26, 35, 44},
		'{2, 5, 7, 10, 17, 22, 30, 37},
		'{2, 4, 6, 8, 14, 19, 25, 31},
		'{1, 3, 5, 7, 12, 16, 21, 27},
		'{1, 3, 4, 6, 11, 14, 19, 23},
		'{1, 2, 4, 5, 9, 12, 16, 20}};
endpackage

// ### tb/mpt_front_model.sv
// behavioural measurement front end: currents, motor state, temperature sensors
`timescale 1ns/1ps
`default_nettype none
module mpt_front_model #(
	parameter int NSENS = 10
)(
	input  wire logic             clk,
	output logic [15:0]           avgCurrent,
	output logic [15:0]           maxCurrent,
	output logic                  motorRunning,
	output logic                  motorStart,
	output logic                  phaseReversed,
	output logic [NSENS-1:0][7:0] temps,
	output logic [NSENS-1:0]      sensorOpen
);
	logic [NSENS-1:0][7:0] tempSet;
	logic [NSENS-1:0]      openSet;
	initial
	begin
		avgCurrent = 16'h0000;
		maxCurrent = 16'h0000;
		motorRunning = 1'b0;
		motorStart = 1'b0;
		phaseReversed = 1'b0;
		temps = '0;
		tempSet = '0;
		sensorOpen = '0;
		openSet = '0;
	end
	// an open sensor flips its reading every cycle, so a stale value never looks valid;
	// flag and reading move together so a reconnect never shows a flipped value
	always @(posedge clk)
	begin
		for (int i = 0; i < NSENS; i++)
			temps[i] <= openSet[i] ? ~temps[i] : tempSet[i];
		sensorOpen <= openSet;
	end
	task automatic setCur(input logic [15:0] a, input logic [15:0] m);
		@(posedge clk);
		avgCurrent <= a;
		maxCurrent <= m;
	endtask
	task automatic sens(input int i, input logic [7:0] v, input logic o);
		@(posedge clk);
		tempSet[i] <= v;
		openSet[i] <= o;
	endtask
	task automatic run(input logic v);
		@(posedge clk);
		motorRunning <= v;
	endtask
	task automatic phase(input logic v);
		@(posedge clk);
		phaseReversed <= v;
	endtask
	task automatic start();
		@(posedge clk);
		motorStart <= 1'b1;
		@(posedge clk);
		motorStart <= 1'b0;
	endtask
endmodule // mpt_front_model
`default_nettype wire

// ### tb/mpt_trip_logic_asserts.sv
// port-level assertions for the motor protection trip logic
`timescale 1ns/1ps
`default_nettype none
module mpt_trip_logic_asserts
	import mpt_pkg::*;
#(
	parameter int NSENS = 10
)(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic [7:0]            addr,
	input wire logic [31:0]           wdata,
	input wire logic                  wr,
	input wire logic [15:0]           avgCurrent,
	input wire logic [15:0]           maxCurrent,
	input wire logic                  motorStart,
	input wire logic                  phaseReversed,
	input wire logic [NSENS-1:0][7:0] temps,
	input wire logic [NSENS-1:0]      sensorOpen,
	input wire logic                  tripOut,
	input wire logic                  scTripOut,
	input wire logic                  olTripOut,
	input wire logic                  ioAlarmOut,
	input wire logic                  openSensorIndication,
	input wire logic                  phaseTripOut,
	input wire logic [7:0]            ambientTemp
);
	// settings shadowed from bus writes; out-of-range writes simply disarm the checks
	logic [15:0] scLvl_q, scDly_q, ioLvl_q;
	logic [7:0]  ctrl_q;
	logic        relRst_q;
	logic        scOn, ioOn, relRst;
	assign relRst = wr && addr == A_CTRL && wdata[CTRL_RESET];
	assign scOn = scLvl_q inside {[SC_LEVEL_LO:SC_LEVEL_HI]} && scDly_q == 16'h0000;
	assign ioOn = ioLvl_q inside {[IO_LEVEL_LO:IO_LEVEL_HI]};
	always_ff @(posedge clk)
	begin
		relRst_q <= relRst;
		if (!rst_n)
		begin
			scLvl_q <= 16'h0000;
			scDly_q <= 16'h0000;
			ioLvl_q <= 16'h0000;
			ctrl_q <= 8'h00;
		end
		else if (wr)
		begin
			if (addr == A_SC_LEVEL) scLvl_q <= wdata[15:0];
			if (addr == A_SC_DELAY) scDly_q <= wdata[15:0];
			if (addr == A_IO_LEVEL) ioLvl_q <= wdata[15:0];
			if (addr == A_CTRL) ctrl_q <= wdata[7:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_sc_instant: assert property (scOn && maxCurrent >= scLvl_q |-> ##[1:2] scTripOut)
		else $error("short circuit trip missing");
	a_sc_latched: assert property (scTripOut && !relRst && !relRst_q |=> scTripOut)
		else $error("short circuit trip dropped without reset");
	a_io_follow: assert property (ioOn && avgCurrent > ioLvl_q |=> ioAlarmOut)
		else $error("overload alarm missing");
	a_io_release: assert property (ioOn && avgCurrent <= ioLvl_q |=> !ioAlarmOut)
		else $error("overload alarm stayed on");
	a_trip_sum: assert property (scTripOut || olTripOut || phaseTripOut |=> tripOut)
		else $error("trip output not raised");
	a_open_flag: assert property (|sensorOpen |=> openSensorIndication)
		else $error("open sensor not flagged");
	a_open_clear: assert property (!(|sensorOpen) |=> !openSensorIndication)
		else $error("open sensor flag without cause");
	a_phase_trip: assert property (ctrl_q[CTRL_PHASE] && motorStart && phaseReversed
		|-> ##[1:4] phaseTripOut)
		else $error("phase reversal trip missing");
	a_ambient_copy: assert property (ctrl_q[CTRL_AMB] && !sensorOpen[NSENS-1]
		|=> ambientTemp == $past(temps[NSENS-1]))
		else $error("ambient reading wrong");
endmodule // mpt_trip_logic_asserts
bind mpt_trip_logic mpt_trip_logic_asserts #(.NSENS(NSENS)) u_asserts (.clk, .rst_n, .addr,
	.wdata, .wr, .avgCurrent, .maxCurrent, .motorStart, .phaseReversed, .temps, .sensorOpen,
	.tripOut, .scTripOut, .olTripOut, .ioAlarmOut, .openSensorIndication, .phaseTripOut,
	.ambientTemp);
`default_nettype wire

// ### tb/mpt_trip_logic_bench.sv
// self-checking bench for the motor protection trip logic
`timescale 1ns/1ps
`default_nettype none
module mpt_trip_logic_bench
	import mpt_pkg::*;
;
	logic              clk, rst_n, wr, rd, motorRunning, motorStart, phaseReversed;
	logic [7:0]        addr, statorMaxTemp, ambientTemp;
	logic [31:0]       wdata, rdata, ctrl;
	logic [15:0]       avgCurrent, maxCurrent, e;
	logic [9:0][7:0]   temps;
	logic [9:0]        sensorOpen;
	logic              tripOut, alarmOut, scTripOut, olTripOut, ioAlarmOut, irq;
	logic              tempTripOut, tempAlarmOut, openSensorIndication, phaseTripOut;
	logic [3:0]        outs;
	int                fails, checked, k;
	assign outs = {irq, phaseTripOut, olTripOut, scTripOut};
	mpt_trip_logic #(.NSENS(10), .TICK_COUNT(10)) u_mpt_trip_logic (.clk, .rst_n, .addr,
		.wdata, .wr, .rd, .rdata, .avgCurrent, .maxCurrent, .motorRunning, .motorStart,
		.phaseReversed, .temps, .sensorOpen, .tripOut, .alarmOut, .scTripOut, .olTripOut,
		.ioAlarmOut, .tempTripOut, .tempAlarmOut, .openSensorIndication, .phaseTripOut,
		.statorMaxTemp, .ambientTemp, .irq);
	mpt_front_model #(.NSENS(10)) u_fe (.clk, .avgCurrent, .maxCurrent, .motorRunning,
		.motorStart, .phaseReversed, .temps, .sensorOpen);
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			fails++;
			$display("Error: %s expected %0h seen %0h", n, x, s);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(n, rdata & m, x);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic waitBit(input string n, input int b, input int lim, output int c);
		#1;
		for (c = 0; c < lim && outs[b] !== 1'b1; c++)
			cyc(1);
		chk(n, {31'h0, outs[b]}, 32'h1);
	endtask
	task automatic done(input string n);
		$display("%s finished, %0d mismatches so far", n, fails);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("Error: run did not finish in time");
		print_verdict();
	end
	initial
	begin
		{rst_n, wr, rd, addr, wdata, fails, checked} = '0;
		ctrl = 32'h0606;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdChk("ctrl", A_CTRL, ctrl);
		rdChk("unmapped", 8'hF0, 32'h0);
		wrReg(A_SC_LEVEL, 32'h0);
		u_fe.setCur(16'h0, 16'h0514);
		cyc(4);
		chk("sc off", {31'h0, scTripOut}, 32'h0);
		u_fe.setCur(16'h0, 16'h0);
		wrReg(A_SC_LEVEL, 32'h0064);
		rdChk("sc lo", A_SC_LEVEL, {16'h0, SC_LEVEL_LO});
		wrReg(A_SC_LEVEL, 32'h1388);
		rdChk("sc hi", A_SC_LEVEL, {16'h0, SC_LEVEL_HI});
		wrReg(A_IRQ_EN, 32'h1);
		wrReg(A_SC_LEVEL, 32'h01F4);
		u_fe.setCur(16'h0, 16'h01F4);
		waitBit("sc", 0, 3, k);
		waitBit("irq", 3, 4, k);
		u_fe.setCur(16'h0, 16'h0);
		wrReg(A_CTRL, ctrl | 32'h80);
		wrReg(A_IRQ_CLR, 32'h1);
		cyc(3);
		chk("sc reset", {31'h0, scTripOut}, 32'h0);
		chk("irq clear", {31'h0, irq}, 32'h0);
		wrReg(A_SC_DELAY, 32'h2);
		u_fe.setCur(16'h0, 16'h0258);
		cyc(5);
		chk("sc early", {31'h0, scTripOut}, 32'h0);
		waitBit("sc delayed", 0, 40, k);
		u_fe.setCur(16'h0, 16'h0);
		wrReg(A_CTRL, ctrl | 32'h80);
		wrReg(A_SC_LEVEL, 32'h0);
		done("short circuit");
		wrReg(A_IO_LEVEL, 32'h0078);
		u_fe.setCur(16'h0079, 16'h0079);
		cyc(2);
		chk("io on", {31'h0, ioAlarmOut}, 32'h1);
		u_fe.setCur(16'h0078, 16'h0078);
		cyc(2);
		chk("io off", {31'h0, ioAlarmOut}, 32'h0);
		wrReg(A_IO_LEVEL, 32'h0);
		done("immediate overload");
		u_fe.setCur(16'h0069, 16'h0069);
		for (int c = 0; c < 8; c++)
		begin
			wrReg(A_CTRL, 32'h0600 | (32'(c) << 1));
			cyc(1);
			rdChk("curve", A_TRIP_TIME, {16'h0, STD_CURVE[0][c]});
		end
		wrReg(A_CTRL, ctrl);
		u_fe.setCur(16'h007D, 16'h007D);
		e = STD_CURVE[2][3] - (STD_CURVE[2][3] - STD_CURVE[3][3]) / 2;
		rdChk("interp", A_TRIP_TIME, {16'h0, e});
		u_fe.setCur(16'h0064, 16'h0064);
		rdChk("below", A_TRIP_TIME, {16'h0, STD_CURVE[0][3]});
		u_fe.run(1'b1);
		wrReg(A_CTRL, 32'h0600);
		rdChk("held", A_TRIP_TIME, {16'h0, STD_CURVE[0][3]});
		rdChk("pending", A_STATE, 32'h100, 32'h100);
		u_fe.run(1'b0);
		cyc(2);
		rdChk("applied", A_TRIP_TIME, {16'h0, STD_CURVE[0][0]});
		wrReg(A_CUSTOM, 32'h0000_0100);
		wrReg(A_CTRL, 32'h0601);
		u_fe.setCur(16'h0069, 16'h0069);
		rdChk("custom", A_TRIP_TIME, 32'h100);
		u_fe.setCur(16'h0064, 16'h0064);
		ctrl = 32'h0600;
		wrReg(A_CTRL, ctrl);
		u_fe.setCur(16'h0320, 16'h0320);
		waitBit("overload", 1, 200, k);
		chk("ol time", {31'h0, k >= 85}, 32'h1);
		u_fe.setCur(16'h0064, 16'h0064);
		wrReg(A_CTRL, ctrl | 32'h80);
		cyc(2);
		chk("ol reset", {31'h0, olTripOut}, 32'h0);
		done("overload curves");
		ctrl = 32'h0200;
		wrReg(A_CTRL, ctrl);
		wrReg(A_TEMP_TRIP + 8'h08, 32'h64);
		u_fe.sens(2, 8'h65, 1'b0);
		cyc(3);
		chk("temp trip", {31'h0, tempTripOut}, 32'h1);
		chk("trip sum", {31'h0, tripOut}, 32'h1);
		u_fe.sens(2, 8'h62, 1'b0);
		wrReg(A_CTRL, ctrl | 32'h80);
		cyc(2);
		chk("temp held", {31'h0, tempTripOut}, 32'h1);
		u_fe.sens(2, 8'h60, 1'b0);
		wrReg(A_CTRL, ctrl | 32'h80);
		cyc(2);
		chk("temp free", {31'h0, tempTripOut}, 32'h0);
		u_fe.sens(0, 8'h32, 1'b0);
		u_fe.sens(1, 8'h46, 1'b0);
		cyc(3);
		chk("stator max", {24'h0, statorMaxTemp}, 32'h46);
		u_fe.sens(1, 8'h46, 1'b1);
		cyc(3);
		chk("open skip", {24'h0, statorMaxTemp}, 32'h32);
		chk("open flag", {31'h0, openSensorIndication}, 32'h1);
		wrReg(A_CTRL, ctrl | 32'h20);
		cyc(2);
		chk("open thr off", {31'h0, alarmOut}, 32'h0);
		wrReg(A_TEMP_ALARM + 8'h04, 32'h80);
		cyc(2);
		chk("open alarm", {31'h0, alarmOut}, 32'h1);
		chk("open no latch", {31'h0, tempAlarmOut}, 32'h0);
		u_fe.sens(1, 8'h46, 1'b0);
		wrReg(A_CTRL, 32'h0240);
		u_fe.sens(9, 8'h21, 1'b0);
		cyc(3);
		chk("ambient", {24'h0, ambientTemp}, 32'h21);
		done("temperature");
		wrReg(A_CTRL, 32'h0210);
		u_fe.phase(1'b1);
		u_fe.start();
		waitBit("phase", 2, 10, k);
		done("phase reversal");
		print_verdict();
	end
endmodule // mpt_trip_logic_bench
`default_nettype wire
